// ==== src/scb_pkg.sv ====
package scb_pkg;

    // register byte offsets
    localparam logic [11:0] SCB_CTRL_OFS       = 12'h000;
    localparam logic [11:0] SCB_STATUS_OFS     = 12'h004;
    localparam logic [11:0] SCB_IRQ_STATUS_OFS = 12'h008;
    localparam logic [11:0] SCB_IRQ_ENABLE_OFS = 12'h00C;
    localparam logic [11:0] SCB_IRQ_CLEAR_OFS  = 12'h010;

    // control register fields
    localparam int          SCB_CTRL_DRIVE_EN  = 0;
    localparam logic [31:0] SCB_CTRL_RESET     = 32'h0000_0001;

    // status register fields
    localparam int SCB_ST_RUN       = 0;
    localparam int SCB_ST_DIR       = 1;
    localparam int SCB_ST_FREQ      = 2;
    localparam int SCB_ST_HARD      = 3;
    localparam int SCB_ST_AUTO_STOP = 4;
    localparam int SCB_ST_HALL_LSB  = 8;
    localparam int SCB_ST_STATE_LSB = 12;
    localparam int SCB_ST_BRAKE_LSB = 16;

    // interrupt event bits
    localparam int SCB_EV_DIR       = 0;
    localparam int SCB_EV_AUTO_STOP = 1;
    localparam int SCB_EV_BAD_HALL  = 2;
    localparam int SCB_EV_FREQ      = 3;
    localparam int SCB_EV_W         = 4;

    // open-pin levels
    localparam logic SCB_OPEN_RUN   = 1'b0;
    localparam logic SCB_OPEN_BRK1  = 1'b0;
    localparam logic SCB_OPEN_BRK2  = 1'b0;
    localparam logic SCB_OPEN_AUTO  = 1'b1;
    localparam logic SCB_OPEN_SENS  = 1'b1;

    // timing
    localparam int SCB_CLK_PS          = 5000;
    localparam int SCB_SOFT_OVERLAP_NS = 100;
    localparam int SCB_FILT_SOFT_NS    = 50;
    localparam int SCB_FILT_HARD_NS    = 20;
    localparam int SCB_SOFT_CYC = (SCB_SOFT_OVERLAP_NS * 1000 + SCB_CLK_PS - 1) / SCB_CLK_PS;
    localparam int SCB_FILT_SOFT_CYC = (SCB_FILT_SOFT_NS * 1000 + SCB_CLK_PS - 1) / SCB_CLK_PS;
    localparam int SCB_FILT_HARD_CYC = (SCB_FILT_HARD_NS * 1000 + SCB_CLK_PS - 1) / SCB_CLK_PS;

    // pad level plus whether anything drives it
    typedef struct packed {
        logic level;
        logic driven;
    } scb_pin_s;

    // one half bridge
    typedef struct packed {
        logic hi;
        logic lo;
    } scb_leg_s;

    typedef struct packed {
        scb_leg_s w;
        scb_leg_s v;
        scb_leg_s u;
    } scb_bridge_s;

    // differential hall pairs
    typedef struct packed {
        logic u_pos;
        logic u_neg;
        logic v_pos;
        logic v_neg;
        logic w_pos;
        logic w_neg;
    } scb_hall_s;

    typedef enum logic [1:0] {
        SCB_SLEEP,
        SCB_DRIVE,
        SCB_BRAKE,
        SCB_AUTO_STOP
    } scb_state_e;

    typedef enum logic [1:0] {
        SCB_BRK_REVERSE,
        SCB_BRK_COMM_SHORT,
        SCB_BRK_ALL_SHORT,
        SCB_BRK_COAST
    } scb_brake_e;

endpackage

// ==== src/scb_spindle_ctrl.sv ====
// Functional notes
// (R1) sensitivity pin open or high: soft commutation, larger hall amplitude needed.
// (R2) sensitivity pin grounded: hard abrupt commutation, smaller hall amplitude accepted.
// (R3) board grounds sensitivity pin for weak halls; open pin with moderate halls preferred.
// (R4) run input low or open: all phase outputs high impedance, motor stops.
// (R5) sleep: hall bias output off and internal bias reduced to standby.
// (R6) run input high: all functions enabled, internal bias and hall bias on.
// (R7) direction indication derived from the U and V hall pairs.
// (R8) direction indication low while spinning forward.
// (R9) direction indication high when turning in reverse during stop.
// (R10) auto-stop open or high: stop driving once reverse braking reaches reverse rotation.
// (R11) auto-stop low: keep reverse torque into reverse rotation until external stop.
// (R12) without auto-stop the controller watches direction and removes torque itself.
// (R13) braking style applies only while reverse torque is demanded.
// (R14) brake one low, brake two high: reverse braking with commutated reverse torque.
// (R15) brake one low: brake two picks reverse braking or commutated short braking.
// (R16) controller picks reverse braking for velocity control, all-short for seeking.
// (R17) frequency output is a square wave following the V hall pair.
// (R18) brake one high: two low shorts all phases, two high opens all phases.
// (R19) open mode or run pin takes its documented default level.
`timescale 1ns/1ps

module scb_spindle_ctrl
    import scb_pkg::*;
#(
    parameter int SOFT_CYC      = SCB_SOFT_CYC,
    parameter int FILT_SOFT_CYC = SCB_FILT_SOFT_CYC,
    parameter int FILT_HARD_CYC = SCB_FILT_HARD_CYC
) (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic [11:0] paddr,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [31:0] pwdata,
    input  wire logic [3:0]  pstrb,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire scb_pin_s    run_control,
    input  wire scb_pin_s    brake_select_one,
    input  wire scb_pin_s    brake_select_two,
    input  wire scb_pin_s    auto_stop_select,
    input  wire scb_pin_s    hall_sensitivity_select,
    input  wire scb_hall_s   hall_in,
    input  wire logic        torque_forward_demand,
    input  wire logic        torque_reverse_demand,
    output scb_bridge_s      phase_drive,
    output logic             soft_commutation,
    output logic             hall_sensor_bias,
    output logic             internal_bias_on,
    output logic             direction_indication,
    output logic             rotation_frequency_output,
    output logic             irq
);

    localparam int CW = 8;

    initial begin
        if (SOFT_CYC < 1 || SOFT_CYC > 255 || FILT_SOFT_CYC < 1 || FILT_SOFT_CYC > 255
            || FILT_HARD_CYC < 1 || FILT_HARD_CYC > 255) begin
            $error("scb_spindle_ctrl: counts must lie in 1..255");
        end
    end

    // resolve a pad: undriven takes its default level
    function automatic logic pin_level(input scb_pin_s p, input logic open_lvl);
        pin_level = p.driven ? p.level : open_lvl;
    endfunction

    // commutation table; reverse swaps source and sink
    function automatic scb_bridge_s commutate(input logic [2:0] h, input logic rev);
        scb_bridge_s b;
        b = '0;
        unique case (h)
            3'b001: begin b.u.hi = 1'b1; b.v.lo = 1'b1; end
            3'b011: begin b.u.hi = 1'b1; b.w.lo = 1'b1; end
            3'b010: begin b.v.hi = 1'b1; b.w.lo = 1'b1; end
            3'b110: begin b.v.hi = 1'b1; b.u.lo = 1'b1; end
            3'b100: begin b.w.hi = 1'b1; b.u.lo = 1'b1; end
            3'b101: begin b.w.hi = 1'b1; b.v.lo = 1'b1; end
            default: b = '0;
        endcase
        if (rev) begin
            b = {b.w.lo, b.w.hi, b.v.lo, b.v.hi, b.u.lo, b.u.hi};
        end
        return b;
    endfunction

    // overlap: a leg the new step leaves idle keeps its old drive
    function automatic scb_leg_s blend(input scb_leg_s o, input scb_leg_s n);
        blend = (n.hi | n.lo) ? n : o;
    endfunction

    function automatic logic legal_hall(input logic [2:0] h);
        legal_hall = (h != 3'b000) && (h != 3'b111);
    endfunction

    // pin resolution
    logic run;
    logic brk1;
    logic brk2;
    logic auto_stop_on;
    logic soft_mode;
    assign run          = pin_level(run_control, SCB_OPEN_RUN);              // R19
    assign brk1         = pin_level(brake_select_one, SCB_OPEN_BRK1);        // R19
    assign brk2         = pin_level(brake_select_two, SCB_OPEN_BRK2);        // R19
    assign auto_stop_on = pin_level(auto_stop_select, SCB_OPEN_AUTO);        // R19
    assign soft_mode    = pin_level(hall_sensitivity_select, SCB_OPEN_SENS); // R1 R2

    // differential compare; equal inputs mean signal too small, keep old bit
    logic [2:0] hall_raw;
    logic [2:0] hall_last_q;
    assign hall_raw[0] = (hall_in.u_pos ^ hall_in.u_neg) ? hall_in.u_pos : hall_last_q[0];
    assign hall_raw[1] = (hall_in.v_pos ^ hall_in.v_neg) ? hall_in.v_pos : hall_last_q[1];
    assign hall_raw[2] = (hall_in.w_pos ^ hall_in.w_neg) ? hall_in.w_pos : hall_last_q[2];

    // deglitch; soft mode wants a longer stable window
    logic [CW-1:0] filt_cnt_q;
    logic [CW-1:0] filt_len;
    logic [2:0]    hall_q;
    logic          hall_step;
    assign filt_len  = soft_mode ? CW'(FILT_SOFT_CYC) : CW'(FILT_HARD_CYC); // R1 R2
    assign hall_step = (hall_raw == hall_last_q) && (filt_cnt_q == filt_len - CW'(1))
                       && (hall_raw != hall_q);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            hall_last_q <= '0;
            filt_cnt_q  <= '0;
            hall_q      <= '0;
        end else begin
            hall_last_q <= hall_raw;
            if (hall_raw != hall_last_q) begin
                filt_cnt_q <= '0;
            end else if (filt_cnt_q != filt_len - CW'(1)) begin
                filt_cnt_q <= filt_cnt_q + CW'(1);
            end
            if (hall_step) begin
                hall_q <= hall_raw;
            end
        end
    end

    // direction from U and V: at a V edge, forward if V now equals U
    logic v_edge;
    logic dir_rev_q;
    logic freq_q;
    assign v_edge = hall_step && (hall_raw[1] != hall_q[1]);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            dir_rev_q <= 1'b0;
        end else if (v_edge) begin
            dir_rev_q <= (hall_raw[1] != hall_raw[0]); // R7 R8 R9
        end
    end

    // frequency output tracks the V hall pair
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            freq_q <= 1'b0;
        end else begin
            freq_q <= hall_q[1]; // R17
        end
    end

    // braking style under reverse torque
    scb_brake_e brake_style;
    always_comb begin
        unique case ({brk1, brk2})
            2'b01: brake_style = SCB_BRK_REVERSE;    // R14 R15
            2'b00: brake_style = SCB_BRK_COMM_SHORT; // R15
            2'b10: brake_style = SCB_BRK_ALL_SHORT;  // R18
            2'b11: brake_style = SCB_BRK_COAST;      // R18
        endcase
    end

    // control state
    logic       drive_en_q;
    scb_state_e state_q;
    logic       auto_stop_hit;
    assign auto_stop_hit = (state_q == SCB_BRAKE) && (brake_style == SCB_BRK_REVERSE)
                           && auto_stop_on && v_edge && (hall_raw[1] != hall_raw[0]);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_q <= SCB_SLEEP;
        end else if (!run) begin
            state_q <= SCB_SLEEP; // R4 R5
        end else begin
            unique case (state_q)
                SCB_SLEEP: begin
                    state_q <= SCB_DRIVE; // R6
                end
                SCB_DRIVE: begin
                    if (torque_reverse_demand) begin
                        state_q <= SCB_BRAKE; // R13
                    end
                end
                SCB_BRAKE: begin
                    if (!torque_reverse_demand) begin
                        state_q <= SCB_DRIVE;
                    end else if (auto_stop_hit) begin
                        state_q <= SCB_AUTO_STOP; // R10
                    end
                end
                SCB_AUTO_STOP: begin
                    if (!torque_reverse_demand) begin
                        state_q <= SCB_DRIVE;
                    end
                end
            endcase
        end
    end

    // bridge pattern for the present state; without auto-stop reverse torque continues
    scb_bridge_s bridge_d;
    scb_bridge_s bridge_q;
    scb_bridge_s target;
    logic        legal;
    assign legal = legal_hall(hall_q);
    always_comb begin
        target = '0;
        if (state_q == SCB_DRIVE && torque_forward_demand && legal) begin
            target = commutate(hall_q, 1'b0);
        end else if (state_q == SCB_BRAKE && legal) begin
            unique case (brake_style)
                SCB_BRK_REVERSE: target = commutate(hall_q, 1'b1); // R11 R14
                SCB_BRK_COMM_SHORT: begin
                    target = commutate(hall_q, 1'b0);
                    target = '{w: '{1'b0, target.w.hi | target.w.lo},
                               v: '{1'b0, target.v.hi | target.v.lo},
                               u: '{1'b0, target.u.hi | target.u.lo}}; // R15
                end
                SCB_BRK_ALL_SHORT: target = '{w: '{1'b0, 1'b1},
                                              v: '{1'b0, 1'b1},
                                              u: '{1'b0, 1'b1}}; // R18
                SCB_BRK_COAST: target = '0; // R18
            endcase
        end
        if (!drive_en_q) begin
            target = '0;
        end
    end

    // soft mode overlaps the outgoing leg for a short window after each step
    logic [CW-1:0] soft_cnt_q;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            soft_cnt_q <= '0;
        end else if (hall_step && soft_mode) begin
            soft_cnt_q <= CW'(SOFT_CYC); // R1
        end else if (!soft_mode) begin
            soft_cnt_q <= '0; // R2
        end else if (soft_cnt_q != '0) begin
            soft_cnt_q <= soft_cnt_q - CW'(1);
        end
    end

    always_comb begin
        bridge_d = target;
        if (soft_cnt_q != '0 && target != '0) begin
            bridge_d.u = blend(bridge_q.u, target.u);
            bridge_d.v = blend(bridge_q.v, target.v);
            bridge_d.w = blend(bridge_q.w, target.w);
        end
    end

    // registered pin drive; sleep forces high impedance and bias off
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            bridge_q         <= '0;
            hall_sensor_bias <= 1'b0;
            internal_bias_on <= 1'b0;
        end else begin
            bridge_q         <= run ? bridge_d : '0; // R4
            hall_sensor_bias <= run;                 // R5 R6
            internal_bias_on <= run;                 // R5 R6
        end
    end

    assign phase_drive               = bridge_q;
    assign soft_commutation          = (soft_cnt_q != '0);
    assign direction_indication      = dir_rev_q; // R8 R9 R12
    assign rotation_frequency_output = freq_q;    // R17

    // apb slave, zero wait states
    logic        apb_wr;
    logic        apb_rd;
    logic        addr_ok;
    logic [31:0] prdata_d;
    logic [SCB_EV_W-1:0] irq_status_q;
    logic [SCB_EV_W-1:0] irq_enable_q;
    logic [SCB_EV_W-1:0] irq_event;
    logic [SCB_EV_W-1:0] irq_clear;
    logic                dir_prev_q;
    assign addr_ok = (paddr == SCB_CTRL_OFS) || (paddr == SCB_STATUS_OFS)
                     || (paddr == SCB_IRQ_STATUS_OFS) || (paddr == SCB_IRQ_ENABLE_OFS)
                     || (paddr == SCB_IRQ_CLEAR_OFS);
    assign apb_wr  = psel && penable && pwrite && addr_ok && pstrb[0];
    assign apb_rd  = psel && penable && !pwrite;
    assign pready  = 1'b1;
    assign pslverr = psel && penable && !addr_ok;

    // writable registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            drive_en_q   <= SCB_CTRL_RESET[SCB_CTRL_DRIVE_EN];
            irq_enable_q <= '0;
        end else if (apb_wr) begin
            if (paddr == SCB_CTRL_OFS) begin
                drive_en_q <= pwdata[SCB_CTRL_DRIVE_EN];
            end
            if (paddr == SCB_IRQ_ENABLE_OFS) begin
                irq_enable_q <= pwdata[SCB_EV_W-1:0];
            end
        end
    end

    // sticky events; a new event beats a clear in the same cycle
    assign irq_event[SCB_EV_DIR]       = (dir_rev_q != dir_prev_q);
    assign irq_event[SCB_EV_AUTO_STOP] = auto_stop_hit;
    assign irq_event[SCB_EV_BAD_HALL]  = hall_step && !legal_hall(hall_raw);
    assign irq_event[SCB_EV_FREQ]      = v_edge;
    assign irq_clear = (apb_wr && paddr == SCB_IRQ_CLEAR_OFS) ? pwdata[SCB_EV_W-1:0] : '0;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_status_q <= '0;
            dir_prev_q   <= 1'b0;
            irq          <= 1'b0;
        end else begin
            dir_prev_q   <= dir_rev_q;
            irq_status_q <= (irq_status_q & ~irq_clear) | irq_event;
            irq          <= |(((irq_status_q & ~irq_clear) | irq_event) & irq_enable_q);
        end
    end

    // read mux
    always_comb begin
        prdata_d = '0;
        unique case (paddr)
            SCB_CTRL_OFS: prdata_d[SCB_CTRL_DRIVE_EN] = drive_en_q;
            SCB_STATUS_OFS: begin
                prdata_d[SCB_ST_RUN]       = run;
                prdata_d[SCB_ST_DIR]       = dir_rev_q;
                prdata_d[SCB_ST_FREQ]      = freq_q;
                prdata_d[SCB_ST_HARD]      = !soft_mode;
                prdata_d[SCB_ST_AUTO_STOP] = (state_q == SCB_AUTO_STOP);
                prdata_d[SCB_ST_HALL_LSB +: 3]  = hall_q;
                prdata_d[SCB_ST_STATE_LSB +: 2] = state_q;
                prdata_d[SCB_ST_BRAKE_LSB +: 2] = brake_style;
            end
            SCB_IRQ_STATUS_OFS: prdata_d[SCB_EV_W-1:0] = irq_status_q;
            SCB_IRQ_ENABLE_OFS: prdata_d[SCB_EV_W-1:0] = irq_enable_q;
            default: prdata_d = '0;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= '0;
        end else if (psel && !penable && !pwrite) begin
            prdata <= prdata_d;
        end else if (!apb_rd) begin
            prdata <= '0;
        end
    end

endmodule

// ==== tb/scb_spindle_ctrl_asserts.sv ====
`timescale 1ns/1ps

// pin side checks
module scb_spindle_ctrl_asserts
    import scb_pkg::*;
(
    input wire logic        pclk,
    input wire logic        presetn,
    input wire scb_pin_s    run_control,
    input wire scb_pin_s    brake_select_one,
    input wire scb_pin_s    brake_select_two,
    input wire scb_pin_s    hall_sensitivity_select,
    input wire scb_hall_s   hall_in,
    input wire logic        torque_forward_demand,
    input wire logic        torque_reverse_demand,
    input wire scb_bridge_s phase_drive,
    input wire logic        soft_commutation,
    input wire logic        hall_sensor_bias,
    input wire logic        internal_bias_on,
    input wire logic        direction_indication,
    input wire logic        rotation_frequency_output
);
    logic run_eff, b1_eff, b2_eff, sens_eff, rev_only, freq;

    // open pins take defaults
    assign run_eff  = run_control.driven ? run_control.level : SCB_OPEN_RUN;
    assign b1_eff   = brake_select_one.driven ? brake_select_one.level : SCB_OPEN_BRK1;
    assign b2_eff   = brake_select_two.driven ? brake_select_two.level : SCB_OPEN_BRK2;
    assign sens_eff = hall_sensitivity_select.driven ? hall_sensitivity_select.level
                                                     : SCB_OPEN_SENS;
    assign rev_only = run_eff && torque_reverse_demand && !torque_forward_demand;
    assign freq     = rotation_frequency_output;

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    a_sleep_legs_off: assert property (!run_eff [*3] |-> phase_drive == 6'h00)
        else $error("legs on in sleep");
    a_bias_on_run: assert property ($rose(run_eff) |=> hall_sensor_bias && internal_bias_on)
        else $error("bias off in run");
    a_bias_off_sleep: assert property ($fell(run_eff) |=> !hall_sensor_bias && !internal_bias_on)
        else $error("bias on in sleep");
    a_dir_from_uv: assert property ($changed(direction_indication) |->
        direction_indication == (hall_in.v_pos != hall_in.u_pos))
        else $error("direction wrong");
    a_freq_tracks_v: assert property ($changed(freq) |-> freq == $past(hall_in.v_pos, 2))
        else $error("freq not v hall");
    a_coast_open: assert property ((rev_only && b1_eff && b2_eff) [*6] |-> phase_drive == 6'h00)
        else $error("coast drives");
    a_all_short_low: assert property ((rev_only && b1_eff && !b2_eff) [*6] |->
        phase_drive == 6'h15)
        else $error("all short wrong");
    a_idle_no_torque: assert property ((run_eff && !torque_forward_demand &&
        !torque_reverse_demand) [*4] |-> phase_drive == 6'h00)
        else $error("legs on idle");
    a_hard_no_soft: assert property (!sens_eff [*4] |-> !soft_commutation)
        else $error("soft in hard");
    a_leg_no_short: assert property (!(phase_drive.u.hi && phase_drive.u.lo) &&
        !(phase_drive.v.hi && phase_drive.v.lo) && !(phase_drive.w.hi && phase_drive.w.lo))
        else $error("leg shorted");
endmodule

// ==== tb/scb_motor_model.sv ====
`timescale 1ns/1ps

// motor: one sixth turn per step
module scb_motor_model
    import scb_pkg::*;
(
    input  wire logic pclk,
    input  wire logic step,
    input  wire logic reverse,
    output scb_hall_s hall_in
);
    logic [2:0] pos_q = 3'h0;
    logic [2:0] code;

    // rotor position
    always @(posedge pclk) begin
        if (step) begin
            if (reverse) pos_q <= (pos_q == 3'h0) ? 3'h5 : pos_q - 3'h1;
            else pos_q <= (pos_q == 3'h5) ? 3'h0 : pos_q + 3'h1;
        end
    end

    // forward order of the w,v,u code
    always_comb begin
        case (pos_q)
            3'h0: code = 3'h1;
            3'h1: code = 3'h3;
            3'h2: code = 3'h2;
            3'h3: code = 3'h6;
            3'h4: code = 3'h4;
            default: code = 3'h5;
        endcase
    end

    // full swing, above the hall minimum
    assign hall_in = {code[0], ~code[0], code[1], ~code[1], code[2], ~code[2]};
endmodule

// ==== tb/testbench.sv ====
`timescale 1ns/1ps

module testbench;
    import scb_pkg::*;
    typedef struct packed {scb_pin_s run, b1, b2; logic fwd, rev; logic [5:0] pd;} scb_row_s;
    localparam scb_pin_s PO = 2'b00, P0 = 2'b01, P1 = 2'b11;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [3:0]  pstrb;
    logic        soft_c, hsb, ibias, dir, freq, irq, step, rev_dir, fwd, rev, err, seen;
    scb_pin_s    run_p, b1_p, b2_p, auto_p, sens_p;
    scb_hall_s   hall;
    scb_bridge_s pd;
    int          n_fail, total_checks, idx;
    logic [2:0]  codes [6] = '{3'h1, 3'h3, 3'h2, 3'h6, 3'h4, 3'h5};
    logic [5:0]  fwd_pat [6] = '{6'h06, 6'h12, 6'h18, 6'h09, 6'h21, 6'h24};
    // hall 001 held; pins vs legs
    scb_row_s    rows [9] = '{
        '{PO, PO, PO, 1'b1, 1'b0, 6'h00}, '{P1, PO, PO, 1'b1, 1'b0, 6'h06},
        '{P1, PO, P1, 1'b0, 1'b1, 6'h09}, '{P1, P0, P0, 1'b0, 1'b1, 6'h05},
        '{P1, P1, P0, 1'b0, 1'b1, 6'h15}, '{P1, P1, P1, 1'b0, 1'b1, 6'h00},
        '{P1, PO, PO, 1'b0, 1'b1, 6'h05}, '{P1, P1, P0, 1'b0, 1'b0, 6'h00},
        '{P0, PO, P1, 1'b1, 1'b0, 6'h00}};

    scb_motor_model motor (.pclk, .step, .reverse(rev_dir), .hall_in(hall));

    scb_spindle_ctrl #(.SOFT_CYC(2), .FILT_SOFT_CYC(2), .FILT_HARD_CYC(1)) dut (
        .pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata, .pstrb, .prdata,
        .pready, .pslverr, .run_control(run_p), .brake_select_one(b1_p),
        .brake_select_two(b2_p), .auto_stop_select(auto_p), .hall_sensitivity_select(sens_p),
        .hall_in(hall), .torque_forward_demand(fwd), .torque_reverse_demand(rev),
        .phase_drive(pd), .soft_commutation(soft_c), .hall_sensor_bias(hsb),
        .internal_bias_on(ibias), .direction_indication(dir),
        .rotation_frequency_output(freq), .irq);

    // 200 MHz
    always #2.5 pclk = ~pclk;

    task automatic check(input string what, input logic [31:0] exp, got);
        total_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, wr, a, d};
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        {rd, err} = {prdata, pslverr};
        {psel, penable} <= 2'b00;
    endtask

    task automatic do_step(input logic back);
        @(posedge pclk);
        {step, rev_dir} <= {1'b1, back};
        @(posedge pclk);
        step <= 1'b0;
        idx = back ? (idx + 5) % 6 : (idx + 1) % 6;
        seen = 1'b0;
        repeat (12) @(negedge pclk) seen = seen | (soft_c === 1'b1);
    endtask

    task automatic irq_chk(input logic exp);
        repeat (3) @(posedge pclk);
        @(negedge pclk);
        check("irq", 32'(exp), 32'(irq));
    endtask

    task automatic complete_run;
        $display("checks %0d mismatches %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    // cuts a hang short
    initial begin
        #50000;
        n_fail++;
        $display("[FAIL] watchdog expected finish seen timeout");
        complete_run;
    end

    initial begin
        {pclk, presetn, psel, penable, pwrite, step, rev_dir, fwd, rev} = '0;
        {paddr, pwdata, n_fail, total_checks, idx} = '0;
        {run_p, b1_p, b2_p, auto_p, sens_p} = '0;
        pstrb = 4'hF;
        repeat (5) @(posedge pclk);
        check("reset legs", 0, 32'(pd));
        check("reset ready", 1, 32'(pready));
        presetn <= 1'b1;
        apb(1'b0, SCB_CTRL_OFS, 0);
        check("ctrl reset", SCB_CTRL_RESET, rd);
        apb(1'b0, 12'h020, 0);
        check("unmapped err", 1, 32'(err));
        check("unmapped data", 0, rd);
        foreach (rows[i]) begin
            @(posedge pclk);
            {run_p, b1_p, b2_p, fwd, rev} <= rows[i][13:6];
            repeat (12) @(posedge pclk);
            @(negedge pclk);
            check("legs", 32'(rows[i].pd), 32'(pd));
            check("hall bias", 32'(rows[i].run.driven & rows[i].run.level), 32'(hsb));
        end
        // forward, soft then hard
        @(posedge pclk);
        {run_p, b1_p, b2_p, fwd, rev} <= {P1, PO, PO, 1'b1, 1'b0};
        for (int k = 0; k < 12; k++) begin
            @(posedge pclk);
            sens_p <= (k < 6) ? PO : P0;
            do_step(1'b0);
            check("soft window", 32'(k < 6), 32'(seen));
            check("legs", 32'(fwd_pat[idx]), 32'(pd));
            check("direction", 0, 32'(dir));
            check("freq out", 32'(codes[idx][1]), 32'(freq));
        end
        // reverse while asleep
        @(posedge pclk);
        {run_p, fwd, sens_p} <= {P0, 1'b0, PO};
        repeat (6) do_step(1'b1);
        check("direction", 1, 32'(dir));
        check("legs", 0, 32'(pd));
        check("biases", 0, 32'({hsb, ibias}));
        // reverse brake, auto stop
        @(posedge pclk);
        {run_p, b2_p, auto_p, rev} <= {P1, P1, PO, 1'b1};
        repeat (6) @(posedge pclk);
        repeat (6) do_step(1'b1);
        check("legs", 0, 32'(pd));
        apb(1'b0, SCB_IRQ_STATUS_OFS, 0);
        check("auto stop event", 1, 32'(rd[SCB_EV_AUTO_STOP]));
        // no auto stop
        @(posedge pclk);
        {auto_p, rev} <= {P0, 1'b0};
        repeat (4) @(posedge pclk);
        rev <= 1'b1;
        repeat (4) @(posedge pclk);
        repeat (6) do_step(1'b1);
        check("legs", 32'({fwd_pat[idx][4], fwd_pat[idx][5], fwd_pat[idx][2],
            fwd_pat[idx][3], fwd_pat[idx][0], fwd_pat[idx][1]}), 32'(pd));
        // controller removes torque
        @(posedge pclk);
        if (dir === 1'b1) rev <= 1'b0;
        repeat (4) @(posedge pclk);
        @(negedge pclk);
        check("legs", 0, 32'(pd));
        // interrupt raised, masked, cleared
        apb(1'b1, SCB_IRQ_ENABLE_OFS, 32'h1 << SCB_EV_AUTO_STOP);
        irq_chk(1'b1);
        apb(1'b1, SCB_IRQ_ENABLE_OFS, 0);
        irq_chk(1'b0);
        apb(1'b1, SCB_IRQ_ENABLE_OFS, 32'h1 << SCB_EV_AUTO_STOP);
        apb(1'b1, SCB_IRQ_CLEAR_OFS, 32'h1 << SCB_EV_AUTO_STOP);
        irq_chk(1'b0);
        apb(1'b0, SCB_IRQ_STATUS_OFS, 0);
        check("auto stop cleared", 0, 32'(rd[SCB_EV_AUTO_STOP]));
        // mid-run reset
        @(posedge pclk);
        fwd <= 1'b1;
        repeat (10) @(posedge pclk);
        presetn <= 1'b0;
        @(negedge pclk);
        check("legs in reset", 0, 32'({pd, hsb, irq}));
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        repeat (3) @(posedge pclk);
        @(negedge pclk);
        check("bias after reset", 1, 32'(hsb));
        complete_run;
    end
endmodule

bind scb_spindle_ctrl scb_spindle_ctrl_asserts u_chk (
    .pclk, .presetn, .run_control, .brake_select_one, .brake_select_two,
    .hall_sensitivity_select, .hall_in, .torque_forward_demand, .torque_reverse_demand,
    .phase_drive, .soft_commutation, .hall_sensor_bias, .internal_bias_on,
    .direction_indication, .rotation_frequency_output);
